//--- shared/atm_pkg.sv
package atm_pkg;
  // Register map, byte addresses on APB
  localparam int ADDR_W = 12;
  localparam logic [ADDR_W-1:0] REG_CTRL = 12'h000;
  localparam logic [ADDR_W-1:0] REG_STAT = 12'h004;
  // Control word fields
  localparam int CWL_LSB = 0;
  localparam int CWL_W = 4;
  localparam int AL_LSB = 4;
  localparam int AL_W = 4;
  localparam int NOM_BIT = 8;
  localparam int WR_BIT = 9;
  localparam int KEEP_BIT = 10;
  localparam int CTRL_W = 11;
  localparam logic [CTRL_W-1:0] CTRL_RST = 11'h005;
  // Status word fields
  localparam int ST_AMODE = 0;
  localparam int ST_WIN = 1;
  localparam int ST_TERM = 2;
  localparam int ST_PD = 3;
  localparam int ST_RESYNC = 4;
  localparam int STAT_W = 5;
  // Latency offsets in link cycles
  localparam logic [4:0] ODTL_OFS = 5'h02;
  localparam logic [4:0] LEAD_OFS = 5'h01;
  // Analog delays in picoseconds, system clock period
  localparam int SYS_PERIOD_PS = 8000;
  localparam int ASYNC_ON_MIN_PS = 2000;
  localparam int ASYNC_ON_MAX_PS = 8500;
  localparam int ASYNC_OFF_MIN_PS = 2000;
  localparam int ASYNC_OFF_MAX_PS = 8500;
  // Least times round up, longest round down, never below one cycle
  localparam int ON_MIN_CYC = (ASYNC_ON_MIN_PS + SYS_PERIOD_PS - 1) / SYS_PERIOD_PS;
  localparam int ON_MAX_CYC = (ASYNC_ON_MAX_PS / SYS_PERIOD_PS < 1) ? 1 :
                              ASYNC_ON_MAX_PS / SYS_PERIOD_PS;
  localparam int OFF_MIN_CYC = (ASYNC_OFF_MIN_PS + SYS_PERIOD_PS - 1) / SYS_PERIOD_PS;
  localparam int ASYNC_CYC = (ON_MIN_CYC < 1) ? 1 : ON_MIN_CYC;
  // Defaults of link cycle counts
  localparam int XPDLL_CYC_DEF = 24;
  localparam int RFC_CYC_DEF = 128;
  localparam int HIST_DEF = 64;
  // Power-down state of the link side
  typedef enum logic [1:0] {
    PS_AWAKE = 2'b01,
    PS_DOWN = 2'b10
  } atm_pd_type;
endpackage

//--- test/atm_ctrl_model.sv
`timescale 1ns/1ps
// Controller side of the termination and clock-enable pins
module atm_ctrl_model (
  // Memory clock
  input wire logic link_ck_in,
  // Pins toward the device
  output logic odt_out,
  output logic cke_out,
  output logic refresh_out,
  output logic idle_out
);
  // Awake, all banks precharged, no termination asked
  initial begin
    odt_out = 1'b0;
    cke_out = 1'b1;
    refresh_out = 1'b0;
    idle_out = 1'b1;
  end
  // Pins move just after an edge and hold for n cycles
  // Odt is never moved inside a window: its effect there is not reliable
  task automatic drive(input logic odt, input logic cke, input int n);
    @(posedge link_ck_in);
    odt_out <= odt;
    cke_out <= cke;
    repeat (n - 1) @(posedge link_ck_in);
  endtask
  // Refresh command, one cycle wide
  task automatic refresh();
    @(posedge link_ck_in);
    refresh_out <= 1'b1;
    @(posedge link_ck_in);
    refresh_out <= 1'b0;
  endtask
endmodule

//--- test/testbench.sv
`timescale 1ns/1ps
module testbench;
  import atm_pkg::*;
  // Timing set for the run; short counts keep the run brief
  localparam int CWL = 5;
  localparam int AL = 2;
  localparam int ODTL = CWL + AL - 2;
  localparam int LEAD = ODTL + 1;
  localparam int XPD = 8;
  localparam int RFC = 16;
  logic sys_clk, sys_rst, psel, penable, pwrite, link_ck, resync;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic pready, pslverr, e, odt, cke, refr, idle, term_on, amode, win;
  int fails, n_tests, n, k;
  // Clocks, the memory clock offset in phase
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  initial begin
    link_ck = 1'b0;
    #13;
    forever #32 link_ck = ~link_ck;
  end
  atm_ctrl_model u_ctrl (.link_ck_in(link_ck), .odt_out(odt), .cke_out(cke),
    .refresh_out(refr), .idle_out(idle));
  atm_term_ctrl #(.XPDLL_CYC(XPD), .RFC_CYC(RFC), .HIST(HIST_DEF)) dut (
    .sys_clk_in(sys_clk), .sys_rst_in(sys_rst), .paddr_in(paddr), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .link_ck_in(link_ck), .odt_pin_in(odt),
    .cke_pin_in(cke), .refresh_cmd_in(refr), .banks_idle_in(idle),
    .loop_resync_in(resync), .term_on_out(term_on), .async_mode_out(amode),
    .window_out(win));
  // Verdict and end of run
  task test_done;
    if (fails == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Compare and count
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task ok(input logic c);
    chk({31'h0, c}, 32'h1);
  endtask
  // APB transfer, held until pready is sampled high
  task apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge sys_clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (pready !== 1'b1) fails++;
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  function automatic logic [31:0] ctl(input int al, input int nom, input int keep);
    return 32'(CWL) | (32'(al) << AL_LSB) | (32'(nom) << NOM_BIT) | (32'(keep) << KEEP_BIT);
  endfunction
  // Sys edges until the termination output reaches v
  task wait_term(input logic v);
    k = 0;
    while (term_on !== v && k < 100) begin
      @(posedge sys_clk);
      #1 k++;
    end
  endtask
  // Length in sys cycles of the next window pulse
  task measure(output int len);
    int w;
    len = 0;
    w = 0;
    while (win !== 1'b1 && w < 100) begin
      @(posedge sys_clk);
      #1 w++;
    end
    while (win === 1'b1 && len < 400) begin
      @(posedge sys_clk);
      #1 len++;
    end
  endtask
  // Reset values, read-only status, unmapped address
  task t_regs;
    apb(1'b0, REG_CTRL, 32'h0);
    chk(q, 32'(CTRL_RST));
    chk({31'h0, e}, 32'h0);
    apb(1'b1, REG_CTRL, 32'hffffffff);
    apb(1'b0, REG_CTRL, 32'h0);
    chk(q, 32'h000007ff);
    apb(1'b1, REG_STAT, 32'h1f);
    apb(1'b0, REG_STAT, 32'h0);
    chk(q, 32'h0);
    apb(1'b0, 12'h008, 32'h0);
    chk({31'h0, e}, 32'h1);
    chk(q, 32'h0);
  endtask
  // Resync forces analog path, additive latency ignored
  task t_async;
    apb(1'b1, REG_CTRL, ctl(8, 1, 1));
    resync <= 1'b1;
    repeat (10) @(posedge sys_clk);
    ok(amode === 1'b1);
    u_ctrl.drive(1'b1, 1'b1, 1);
    wait_term(1'b1);
    ok(k >= 3 && k <= 4);
    u_ctrl.drive(1'b0, 1'b1, 1);
    wait_term(1'b0);
    ok(k >= 3 && k <= 4);
    resync <= 1'b0;
  endtask
  // Latency-based path with the loop kept
  task t_sync;
    apb(1'b1, REG_CTRL, ctl(AL, 1, 1));
    repeat (10) @(posedge sys_clk);
    // Let the earlier pin pulse drain out of the latency line
    u_ctrl.drive(1'b0, 1'b1, 20);
    ok(amode === 1'b0);
    u_ctrl.drive(1'b1, 1'b1, 1);
    wait_term(1'b1);
    ok(k >= (ODTL + 1) * 8 && k <= (ODTL + 2) * 8 + 6);
    u_ctrl.drive(1'b0, 1'b1, 1);
    wait_term(1'b0);
    ok(k >= (ODTL + 1) * 8 && k <= (ODTL + 2) * 8 + 6);
  endtask
  // Entry and exit windows with the loop off
  task t_pd;
    apb(1'b1, REG_CTRL, ctl(AL, 1, 0));
    fork
      u_ctrl.drive(1'b0, 1'b0, 30);
      measure(n);
    join
    ok(n >= LEAD * 8 - 6 && n <= LEAD * 8 + 6);
    ok(amode === 1'b1);
    apb(1'b0, REG_STAT, 32'h0);
    chk(q, (32'h1 << ST_AMODE) | (32'h1 << ST_PD));
    fork
      u_ctrl.drive(1'b0, 1'b1, 30);
      measure(n);
    join
    ok(n >= (LEAD + XPD) * 8 - 6 && n <= (LEAD + XPD) * 8 + 6);
    ok(amode === 1'b0);
  endtask
  // Loop kept: no windows, no analog mode
  task t_keep;
    apb(1'b1, REG_CTRL, ctl(AL, 1, 1));
    fork
      u_ctrl.drive(1'b0, 1'b0, 20);
      measure(n);
    join
    chk(n, 32'h0);
    ok(amode === 1'b0);
    u_ctrl.drive(1'b0, 1'b1, 20);
  endtask
  // Refresh running at entry stretches the window
  task t_ref;
    apb(1'b1, REG_CTRL, ctl(AL, 1, 0));
    fork
      begin
        u_ctrl.refresh();
        u_ctrl.drive(1'b0, 1'b0, 30);
      end
      measure(n);
    join
    ok(n > LEAD * 8 + 6 && n <= RFC * 8 + 6);
    u_ctrl.drive(1'b0, 1'b1, 30);
  endtask
  // One-cycle low pulse: entry and exit merge into one window
  task t_short;
    fork
      begin
        u_ctrl.drive(1'b0, 1'b0, 1);
        u_ctrl.drive(1'b0, 1'b1, 30);
      end
      measure(n);
    join
    ok(n >= (LEAD + XPD) * 8 - 6 && n <= (2 * LEAD + XPD + 2) * 8 + 6);
  endtask
  // Both terminations off: pin has no effect, no analog mode
  task t_off;
    apb(1'b1, REG_CTRL, ctl(AL, 0, 0));
    resync <= 1'b1;
    u_ctrl.drive(1'b1, 1'b1, 10);
    ok(term_on === 1'b0);
    ok(amode === 1'b0);
    u_ctrl.drive(1'b0, 1'b1, 2);
    resync <= 1'b0;
  endtask
  // Hang guard
  initial begin
    #300000;
    fails++;
    test_done;
  end
  // Main sequence; link logic leaves reset on its own clock
  initial begin
    fails = 0;
    n_tests = 0;
    sys_rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    resync = 1'b0;
    repeat (6) @(posedge sys_clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge link_ck);
    t_regs;
    t_async;
    t_sync;
    t_pd;
    t_keep;
    t_ref;
    t_short;
    t_off;
    test_done;
  end
endmodule

//--- verilog/atm_term_ctrl.sv
`timescale 1ns/1ps
module atm_term_ctrl #(
  parameter int XPDLL_CYC = atm_pkg::XPDLL_CYC_DEF,
  parameter int RFC_CYC = atm_pkg::RFC_CYC_DEF,
  parameter int HIST = atm_pkg::HIST_DEF
) (
  // System clock and reset
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  // APB slave
  input wire logic [atm_pkg::ADDR_W-1:0] paddr_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // Link side, on the memory clock
  input wire logic link_ck_in,
  input wire logic odt_pin_in,
  input wire logic cke_pin_in,
  input wire logic refresh_cmd_in,
  input wire logic banks_idle_in,
  // Locked loop status, system clock
  input wire logic loop_resync_in,
  // Termination control and status
  output logic term_on_out,
  output logic async_mode_out,
  output logic window_out
);
  import atm_pkg::*;

  // ---------------- System domain: APB registers
  logic [CTRL_W-1:0] ctrl_r; // Configuration word
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;
  logic [STAT_W-1:0] stat_w;
  wire setup_w = psel_in & ~penable_in;
  wire hit_ctrl_w = (paddr_in == REG_CTRL);
  wire hit_stat_w = (paddr_in == REG_STAT);
  wire mapped_w = hit_ctrl_w | hit_stat_w;
  wire wr_go_w = psel_in & penable_in & pready_r & pwrite_in & hit_ctrl_w;
  wire [31:0] rd_mux_w = hit_ctrl_w ? {{(32-CTRL_W){1'b0}}, ctrl_r} :
                         hit_stat_w ? {{(32-STAT_W){1'b0}}, stat_w} : 32'h0000_0000;

  // Answer prepared in setup, so pready is high in the first access cycle
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      pready_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end else begin
      pready_r <= setup_w;
      prdata_r <= setup_w ? rd_mux_w : 32'h0000_0000;
      pslverr_r <= setup_w & ~mapped_w;
    end
  end

  // Control word write; the status word ignores writes
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      ctrl_r <= CTRL_RST;
    end else if (wr_go_w) begin
      ctrl_r <= pwdata_in[CTRL_W-1:0];
    end
  end

  // ---------------- Link reset, asserted at once, released on link clock
  logic lrst_m;
  logic lrst_r;
  always_ff @(posedge link_ck_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      lrst_m <= 1'b1;
      lrst_r <= 1'b1;
    end else begin
      lrst_m <= 1'b0;
      lrst_r <= lrst_m;
    end
  end

  // ---------------- Configuration into link domain
  // Quasi-static: software must not change it while the link is active
  logic [CTRL_W-1:0] lcfg_m;
  logic [CTRL_W-1:0] lcfg_r;
  always_ff @(posedge link_ck_in or posedge lrst_r) begin
    if (lrst_r) begin
      lcfg_m <= CTRL_RST;
      lcfg_r <= CTRL_RST;
    end else begin
      lcfg_m <= ctrl_r;
      lcfg_r <= lcfg_m;
    end
  end

  wire [4:0] cwl_w = {1'b0, lcfg_r[CWL_LSB +: CWL_W]};
  wire [4:0] al_w = {1'b0, lcfg_r[AL_LSB +: AL_W]};
  wire [4:0] wl_w = cwl_w + al_w;
  wire term_en_l = lcfg_r[NOM_BIT] | lcfg_r[WR_BIT];
  wire keep_l = lcfg_r[KEEP_BIT];
  // Latency floor at zero for tiny settings
  wire [4:0] odtl_w = (wl_w < ODTL_OFS) ? 5'h00 : wl_w - ODTL_OFS;
  wire [4:0] lead_w = odtl_w + LEAD_OFS;
  wire [6:0] exit_lim_w = {2'b00, lead_w} + 7'(XPDLL_CYC);

  // ---------------- Link pins, registered on the memory clock
  logic odt_q;
  logic cke_q;
  logic cke_d;
  logic ref_q;
  logic idle_q;
  always_ff @(posedge link_ck_in or posedge lrst_r) begin
    if (lrst_r) begin
      odt_q <= 1'b0;
      cke_q <= 1'b1; // Idle level of the pin, so no false edge after reset
      cke_d <= 1'b1;
      ref_q <= 1'b0;
      idle_q <= 1'b1;
    end else begin
      odt_q <= odt_pin_in;
      cke_q <= cke_pin_in;
      cke_d <= cke_q;
      ref_q <= refresh_cmd_in;
      idle_q <= banks_idle_in;
    end
  end

  // First registered low and first registered high of clock enable
  wire fall_now_w = cke_d & ~cke_q;
  wire rise_now_w = ~cke_d & cke_q;

  // ---------------- Histories: termination pin and clock enable edges
  logic [HIST-1:0] odt_hist_r;
  logic [HIST-1:0] fall_hist_r;
  logic [HIST-1:0] rise_hist_r;
  always_ff @(posedge link_ck_in or posedge lrst_r) begin
    if (lrst_r) begin
      odt_hist_r <= '0;
      fall_hist_r <= '0;
      rise_hist_r <= '0;
    end else begin
      odt_hist_r <= {odt_hist_r[HIST-2:0], odt_q};
      fall_hist_r <= {fall_hist_r[HIST-2:0], fall_now_w};
      rise_hist_r <= {rise_hist_r[HIST-2:0], rise_now_w};
    end
  end

  wire [HIST:0] odt_vec_w = {odt_hist_r, odt_q};
  wire [HIST:0] fall_vec_w = {fall_hist_r, fall_now_w};
  wire [HIST:0] rise_vec_w = {rise_hist_r, rise_now_w};
  logic [HIST:0] lead_mask_w;
  logic [HIST:0] exit_mask_w;

  // Window masks, one bit per history entry
  genvar gi;
  generate
    for (gi = 0; gi <= HIST; gi++) begin : g_mask
      assign lead_mask_w[gi] = (7'(gi) < {2'b00, lead_w});
      assign exit_mask_w[gi] = (7'(gi) < exit_lim_w);
    end
  endgenerate

  // Status trails by the lead time: a window opens before the edge
  // that defines it, so it is only known once that edge has come
  wire entry_v_w = |(fall_vec_w & lead_mask_w);
  wire exit_v_w = |(rise_vec_w & exit_mask_w);

  // ---------------- Refresh in flight
  logic [15:0] rfc_cnt_r;
  logic ext_r; // Entry stretched by a running refresh
  wire rfc_busy_w = (rfc_cnt_r != 16'h0000);
  always_ff @(posedge link_ck_in or posedge lrst_r) begin
    if (lrst_r) begin
      rfc_cnt_r <= 16'h0000;
    end else if (ref_q) begin
      rfc_cnt_r <= 16'(RFC_CYC);
    end else if (rfc_busy_w) begin
      rfc_cnt_r <= rfc_cnt_r - 16'h0001;
    end
  end

  // Longer of the two spans: held until the refresh time runs out
  always_ff @(posedge link_ck_in or posedge lrst_r) begin
    if (lrst_r) begin
      ext_r <= 1'b0;
    end else if (fall_now_w & rfc_busy_w) begin
      ext_r <= 1'b1;
    end else if (!rfc_busy_w) begin
      ext_r <= 1'b0;
    end
  end

  // ---------------- Power-down state
  atm_pd_type pd_st_r;
  atm_pd_type pd_nxt;
  always_comb begin
    case (pd_st_r)
      PS_AWAKE: begin
        // Only precharge power-down counts; active power-down stays sync
        pd_nxt = (~cke_q & idle_q) ? PS_DOWN : PS_AWAKE;
      end
      PS_DOWN: begin
        pd_nxt = cke_q ? PS_AWAKE : PS_DOWN;
      end
      default: begin
        pd_nxt = PS_AWAKE;
      end
    endcase
  end

  always_ff @(posedge link_ck_in or posedge lrst_r) begin
    if (lrst_r) begin
      pd_st_r <= PS_AWAKE;
    end else begin
      pd_st_r <= pd_nxt;
    end
  end

  // ---------------- Link outputs toward system domain
  logic sync_term_r; // Latency-delayed termination request
  logic amode_r; // Asynchronous mode in power-down
  logic win_r; // Mixed-behaviour window
  wire pd_w = (pd_st_r == PS_DOWN);
  always_ff @(posedge link_ck_in or posedge lrst_r) begin
    if (lrst_r) begin
      sync_term_r <= 1'b0;
      amode_r <= 1'b0;
      win_r <= 1'b0;
    end else begin
      sync_term_r <= odt_vec_w[odtl_w];
      amode_r <= term_en_l & pd_w & ~keep_l;
      // Union covers merged windows of short pulses either way
      win_r <= term_en_l & ~keep_l & (entry_v_w | exit_v_w | ext_r);
    end
  end

  // ---------------- Crossings into system domain, two flops each
  logic [4:0] x_m;
  logic [4:0] x_s;
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      x_m <= 5'h00;
      x_s <= 5'h00;
    end else begin
      x_m <= {odt_pin_in, pd_w, win_r, amode_r, sync_term_r};
      x_s <= x_m;
    end
  end
  wire sync_s_w = x_s[0];
  wire amode_s_w = x_s[1];
  wire win_s_w = x_s[2];
  wire pd_s_w = x_s[3];
  wire odt_s_w = x_s[4];
  wire term_en_s_w = ctrl_r[NOM_BIT] | ctrl_r[WR_BIT];

  // ---------------- Asynchronous path: fixed delay, no additive latency
  logic [ASYNC_CYC-1:0] adly_r;
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      adly_r <= '0;
    end else begin
      adly_r <= ASYNC_CYC'({adly_r, odt_s_w});
    end
  end
  wire async_term_w = adly_r[ASYNC_CYC-1];

  // With a termination enabled, resync of the loop forces async handling, as does precharge power-down with the loop off
  wire amode_all_w = term_en_s_w & (amode_s_w | loop_resync_in);

  // ---------------- Final outputs, all from flops
  logic term_on_r;
  logic amode_out_r;
  logic win_out_r;
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      term_on_r <= 1'b0;
      amode_out_r <= 1'b0;
      win_out_r <= 1'b0;
    end else begin
      term_on_r <= term_en_s_w & (amode_all_w ? async_term_w : sync_s_w);
      amode_out_r <= amode_all_w;
      win_out_r <= win_s_w;
    end
  end

  assign stat_w = {loop_resync_in, pd_s_w, term_on_r, win_out_r, amode_out_r};
  assign prdata_out = prdata_r;
  assign pready_out = pready_r;
  assign pslverr_out = pslverr_r;
  assign term_on_out = term_on_r;
  assign async_mode_out = amode_out_r;
  assign window_out = win_out_r;

  // ---------------- Checks
  sequence s_fall_nokeep;
    $fell(cke_q) && !keep_l && term_en_l;
  endsequence
  sequence s_rise_nokeep;
    $rose(cke_q) && !keep_l && term_en_l;
  endsequence

  async_on_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    ($rose(odt_s_w) && $stable(amode_all_w) && amode_all_w) |-> ##2 term_on_r)
    else $error("async turn-on late");
  async_off_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    ($fell(odt_s_w) && $stable(amode_all_w) && amode_all_w) |-> ##2 !term_on_r)
    else $error("async turn-off late");
  resync_mode_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    (loop_resync_in && term_en_s_w) |-> ##1 amode_out_r)
    else $error("resync not async");
  pd_mode_a: assert property (@(posedge link_ck_in) disable iff (lrst_r)
    (pd_w && term_en_l && !keep_l) |-> ##1 amode_r)
    else $error("power-down not async");
  keep_nowin_a: assert property (@(posedge link_ck_in) disable iff (lrst_r)
    (keep_l && $past(keep_l)) |-> ##1 !win_r)
    else $error("window with keep bit set");
  entry_win_a: assert property (@(posedge link_ck_in) disable iff (lrst_r)
    s_fall_nokeep |-> ##1 win_r [*2])
    else $error("entry window missing");
  exit_win_a: assert property (@(posedge link_ck_in) disable iff (lrst_r)
    s_rise_nokeep |-> ##1 win_r [*8])
    else $error("exit window too short");
  refresh_ext_a: assert property (@(posedge link_ck_in) disable iff (lrst_r)
    (fall_now_w && rfc_busy_w) |-> ##1 ext_r)
    else $error("refresh stretch missing");
  sync_lat_a: assert property (@(posedge link_ck_in) disable iff (lrst_r)
    (odtl_w == 5'h05 && $stable(odtl_w) && $rose(odt_q)) |-> ##6 sync_term_r)
    else $error("sync latency wrong");
endmodule
